// ==== core/dcs_cfg_reg.sv ====
// Configuration field register with range check and bit mask
`timescale 1ns/1ps
module dcs_cfg_reg #(
  parameter int          W    = 8,
  parameter logic [W-1:0] MASK = '1,
  parameter logic [31:0] MAXV = 32'h0000_00FF,
  parameter logic [W-1:0] RST  = '0
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rst_n,  // Async reset, active low
  input  wire logic         we,     // Write strobe
  input  wire logic [31:0]  wd,     // Write data
  output logic      [W-1:0] q       // Stored field
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // Out-of-range codes are dropped, unimplemented bits stay zero
  always_comb begin
    q_next = q_reg;
    if (we && (wd <= MAXV)) begin
      q_next = wd[W-1:0] & MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= RST;
    end else begin
      q_reg <= q_next;
    end
  end
  assign q = q_reg;
endmodule

// ==== core/dcs_pkg.sv ====
// Shared constants and types for the demodulator configuration and status bank
package dcs_pkg;
  // Byte offsets on the register bus
  localparam logic [7:0] OFS_DATA_INV  = 8'h00;
  localparam logic [7:0] OFS_A5_MASK   = 8'h04;
  localparam logic [7:0] OFS_PAIR      = 8'h08;
  localparam logic [7:0] OFS_SP_MODE   = 8'h0C;
  localparam logic [7:0] OFS_SP_LINE   = 8'h10;
  localparam logic [7:0] OFS_SP_RATE   = 8'h14;
  localparam logic [7:0] OFS_SP_CHAR   = 8'h18;
  localparam logic [7:0] OFS_OH_TYPE   = 8'h1C;
  localparam logic [7:0] OFS_OW_MODE   = 8'h20;
  localparam logic [7:0] OFS_PAT_RSVD  = 8'h24;
  localparam logic [7:0] OFS_SNR_THR   = 8'h28;
  localparam logic [7:0] OFS_SWEEP     = 8'h2C;
  localparam logic [7:0] OFS_STREAM    = 8'h30;
  localparam logic [7:0] OFS_FRAMING   = 8'h34;
  localparam logic [7:0] OFS_A6_MASK   = 8'h38;
  localparam logic [7:0] OFS_DEINT     = 8'h3C;
  localparam logic [7:0] OFS_CTL_SRC   = 8'h40;
  localparam logic [7:0] OFS_REVISION  = 8'h44;
  localparam logic [7:0] OFS_ALM1      = 8'h48;
  localparam logic [7:0] OFS_ALM2      = 8'h4C;
  localparam logic [7:0] OFS_ALM3      = 8'h50;
  localparam logic [7:0] OFS_ALM4      = 8'h54;
  localparam logic [7:0] OFS_SHARED1   = 8'h58;
  localparam logic [7:0] OFS_SHARED2   = 8'h5C;
  // Values after reset
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [17:0] RST_SWEEP    = 18'h00000;
  // Implemented bits of masks and status bytes
  localparam logic [7:0] MASK_A5       = 8'h4D;
  localparam logic [7:0] MASK_A6       = 8'h07;
  localparam logic [7:0] MASK_A3       = 8'h7D;
  localparam logic [7:0] MASK_C1       = 8'h07;
  localparam logic [7:0] FAIL_A1       = 8'hBF;
  localparam logic [7:0] FAIL_A2       = 8'h7F;
  localparam logic [7:0] FAIL_A4       = 8'hC0;
  localparam int         SUM_BIT       = 7;
  // Accepted code ranges
  localparam logic [31:0] MAX_INV      = 32'h0000_0003;
  localparam logic [31:0] MAX_BIT      = 32'h0000_0001;
  localparam logic [31:0] MAX_RATE     = 32'h0000_0007;
  localparam logic [31:0] MAX_OW       = 32'h0000_0002;
  localparam logic [31:0] MAX_FRAME    = 32'h0000_0002;
  localparam logic [31:0] MAX_SNR      = 32'h0000_0063;
  localparam logic [31:0] MAX_SWEEP    = 32'h0003_E418;
  localparam logic [31:0] MAX_MASK     = 32'h0000_00FF;
  // Decoded codes
  localparam logic [1:0]  OW_ONLY      = 2'h2;
  localparam logic [1:0]  FRM_NONE     = 2'h2;
  localparam logic [7:0]  PKT_188      = 8'hBC;
  localparam logic [7:0]  PKT_204      = 8'hCC;
  localparam logic [7:0]  PKT_NONE     = 8'h00;
  localparam logic [14:0] BAUD_TAB [0:7] = '{15'h0096, 15'h012C, 15'h0258, 15'h04B0,
                                              15'h0960, 15'h12C0, 15'h2580, 15'h4B00};
  // Alarm and control source pins
  typedef struct packed {
    logic [1:0] ctl_src;
    logic [7:0] g1;
    logic [7:0] g2;
    logic [7:0] g3;
    logic [7:0] g4;
    logic [7:0] g5;
    logic [7:0] g6;
    logic [7:0] c1;
  } dcs_alarm_t;
  // Decoded controls toward the datapath
  typedef struct packed {
    logic        inv_terr;
    logic        inv_base;
    logic        pair_swap;
    logic        sp_enhanced;
    logic        sp_rs485;
    logic [14:0] sp_baud;
    logic        sp_8bit;
    logic        oh_64k;
    logic        ow_enable;
    logic        ow_only;
    logic [6:0]  snr_thr;
    logic [17:0] sweep_lim;
    logic        terr_burst;
    logic        terr_unframed;
    logic [7:0]  pkt_len;
    logic        deint_en;
  } dcs_ctl_t;
endpackage

// ==== core/dcs_sync.sv ====
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module dcs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rst_n,  // Async reset, active low
  input  wire logic [W-1:0] d,      // Asynchronous level
  output logic      [W-1:0] q       // Synchronised level
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule

// ==== core/dcs_top.sv ====
// Demodulator configuration and status byte bank behind an AHB-Lite slave
//
// Summary of operation
// - Inversion code 0 none, 1 terrestrial, 2 baseband, 3 both
// - Group 5 mask bits 0,2,3,6; 0 masks, 1 allows
// - Group 6 mask bits 0..2; bits 3..7 spare
// - Symbol pairing 0 normal, 1 swapped
// - Service port mode 0 normal, 1 enhanced
// - Service port line 0 RS-232, 1 RS-485
// - Rate codes 0..7 give 150 to 19200 baud
// - Character length 0 seven bits, 1 eight bits
// - Overhead 0 voice 32k, 1 data 64k
// - Orderwire 0 off, 1 on, 2 orderwire only
// - Low SNR threshold 0..99 tenths of dB
// - Sweep limit in 1 Hz steps, 0..255000
// - Terrestrial streaming 0 continuous, 1 burst
// - Framing 0 188-byte, 1 204-byte, 2 unframed
// - Deinterleaver 0 off, 1 on
// - Control source reads 0 panel, 1 terminal, 2 computer
// - Group 1 failure bits, bit 6 shows receive activity
// - Group 2 buffer, Reed-Solomon faults, bit 7 summary
// - Group 3 lock bits read 1 on lock
// - Group 4 activity bits 0..5, fallback 6, low SNR 7
// - Group 3 bit 5 shows test pattern lock
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module dcs_top
  import dcs_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h10  // Arbitrary value
) (
  input  wire logic        hclk,          // System clock
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Byte address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write when high
  input  wire logic [2:0]  hsize,         // Transfer size
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready
  output logic      [31:0] hrdata,        // Read data
  output logic             hreadyout,     // Slave ready
  output logic             hresp,         // Always OKAY
  input  wire dcs_alarm_t  alarm_pins,    // Raw alarm and source pins
  output dcs_ctl_t         ctl,           // Decoded controls
  output logic             summary_fault  // Summary fault level
);
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_READ = 1'b1
  } dcs_state_t;

  dcs_state_t  st_reg, st_next;
  logic [7:0]  addr_reg, addr_next;
  logic        hit_reg, hit_next;
  logic        wr_reg, wr_next;
  logic        rdy_reg, rdy_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        sum_reg, sum_next;
  dcs_ctl_t    ctl_reg, ctl_next;
  dcs_alarm_t  alm;
  logic        addr_ph;
  logic        fault_any;
  logic [31:0] rd_mux;
  logic [15:0] wsel;

  // Configuration fields
  logic [1:0]  inv_q;
  logic [7:0]  mask5_q;
  logic        pair_q;
  logic        spmode_q;
  logic        spline_q;
  logic [2:0]  rate_q;
  logic        char_q;
  logic        oh_q;
  logic [1:0]  ow_q;
  logic [6:0]  snr_q;
  logic [17:0] sweep_q;
  logic        stream_q;
  logic [1:0]  frm_q;
  logic [7:0]  mask6_q;
  logic        deint_q;

  // Pins cross into the clock domain through two flops
  dcs_sync #(.W($bits(dcs_alarm_t))) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (alarm_pins),
    .q     (alm)
  );

  // Write strobes per configuration register during the data phase
  always_comb begin
    wsel = '0;
    if (wr_reg && hit_reg) begin
      wsel[addr_reg[5:2]] = (addr_reg[7:6] == 2'h0);  // Upper offsets never alias the fields
    end
  end

  dcs_cfg_reg #(.W(2), .MASK(2'h3), .MAXV(MAX_INV), .RST(2'h0)) u_inv (
    .clk(hclk), .rst_n(hresetn), .we(wsel[0]), .wd(hwdata), .q(inv_q));
  dcs_cfg_reg #(.W(8), .MASK(MASK_A5), .MAXV(MAX_MASK), .RST(RST_BYTE)) u_mask5 (
    .clk(hclk), .rst_n(hresetn), .we(wsel[1]), .wd(hwdata), .q(mask5_q));
  dcs_cfg_reg #(.W(1), .MASK(1'h1), .MAXV(MAX_BIT), .RST(1'h0)) u_pair (
    .clk(hclk), .rst_n(hresetn), .we(wsel[2]), .wd(hwdata), .q(pair_q));
  dcs_cfg_reg #(.W(1), .MASK(1'h1), .MAXV(MAX_BIT), .RST(1'h0)) u_spmode (
    .clk(hclk), .rst_n(hresetn), .we(wsel[3]), .wd(hwdata), .q(spmode_q));
  dcs_cfg_reg #(.W(1), .MASK(1'h1), .MAXV(MAX_BIT), .RST(1'h0)) u_spline (
    .clk(hclk), .rst_n(hresetn), .we(wsel[4]), .wd(hwdata), .q(spline_q));
  dcs_cfg_reg #(.W(3), .MASK(3'h7), .MAXV(MAX_RATE), .RST(3'h0)) u_rate (
    .clk(hclk), .rst_n(hresetn), .we(wsel[5]), .wd(hwdata), .q(rate_q));
  dcs_cfg_reg #(.W(1), .MASK(1'h1), .MAXV(MAX_BIT), .RST(1'h0)) u_char (
    .clk(hclk), .rst_n(hresetn), .we(wsel[6]), .wd(hwdata), .q(char_q));
  dcs_cfg_reg #(.W(1), .MASK(1'h1), .MAXV(MAX_BIT), .RST(1'h0)) u_oh (
    .clk(hclk), .rst_n(hresetn), .we(wsel[7]), .wd(hwdata), .q(oh_q));
  dcs_cfg_reg #(.W(2), .MASK(2'h3), .MAXV(MAX_OW), .RST(2'h0)) u_ow (
    .clk(hclk), .rst_n(hresetn), .we(wsel[8]), .wd(hwdata), .q(ow_q));
  dcs_cfg_reg #(.W(7), .MASK(7'h7F), .MAXV(MAX_SNR), .RST(7'h00)) u_snr (
    .clk(hclk), .rst_n(hresetn), .we(wsel[10]), .wd(hwdata), .q(snr_q));
  dcs_cfg_reg #(.W(18), .MASK(18'h3FFFF), .MAXV(MAX_SWEEP), .RST(RST_SWEEP)) u_sweep (
    .clk(hclk), .rst_n(hresetn), .we(wsel[11]), .wd(hwdata), .q(sweep_q));
  dcs_cfg_reg #(.W(1), .MASK(1'h1), .MAXV(MAX_BIT), .RST(1'h0)) u_stream (
    .clk(hclk), .rst_n(hresetn), .we(wsel[12]), .wd(hwdata), .q(stream_q));
  dcs_cfg_reg #(.W(2), .MASK(2'h3), .MAXV(MAX_FRAME), .RST(2'h0)) u_frm (
    .clk(hclk), .rst_n(hresetn), .we(wsel[13]), .wd(hwdata), .q(frm_q));
  dcs_cfg_reg #(.W(8), .MASK(MASK_A6), .MAXV(MAX_MASK), .RST(RST_BYTE)) u_mask6 (
    .clk(hclk), .rst_n(hresetn), .we(wsel[14]), .wd(hwdata), .q(mask6_q));
  dcs_cfg_reg #(.W(1), .MASK(1'h1), .MAXV(MAX_BIT), .RST(1'h0)) u_deint (
    .clk(hclk), .rst_n(hresetn), .we(wsel[15]), .wd(hwdata), .q(deint_q));

  // Bus handshake: writes take no wait, reads take one wait state
  assign addr_ph = hsel && htrans[1] && hready;
  always_comb begin
    st_next    = st_reg;
    addr_next  = addr_reg;
    hit_next   = hit_reg;
    wr_next    = 1'b0;
    rdy_next   = rdy_reg;
    rdata_next = rdata_reg;
    unique case (st_reg)
      ST_IDLE: begin
        if (addr_ph) begin
          addr_next = haddr[7:0];
          hit_next  = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
          if (hwrite) begin
            wr_next = 1'b1;
          end else begin
            st_next  = ST_READ;
            rdy_next = 1'b0;
          end
        end
      end
      ST_READ: begin
        rdata_next = hit_reg ? rd_mux : 32'h0000_0000;
        rdy_next   = 1'b1;
        st_next    = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg    <= ST_IDLE;
      addr_reg  <= 8'h00;
      hit_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      rdy_reg   <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      st_reg    <= st_next;
      addr_reg  <= addr_next;
      hit_reg   <= hit_next;
      wr_reg    <= wr_next;
      rdy_reg   <= rdy_next;
      rdata_reg <= rdata_next;
    end
  end

  // Read view; reserved bits and unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_reg)
      OFS_DATA_INV: rd_mux = {30'h0, inv_q};
      OFS_A5_MASK:  rd_mux = {24'h0, mask5_q};
      OFS_PAIR:     rd_mux = {31'h0, pair_q};
      OFS_SP_MODE:  rd_mux = {31'h0, spmode_q};
      OFS_SP_LINE:  rd_mux = {31'h0, spline_q};
      OFS_SP_RATE:  rd_mux = {29'h0, rate_q};
      OFS_SP_CHAR:  rd_mux = {31'h0, char_q};
      OFS_OH_TYPE:  rd_mux = {31'h0, oh_q};
      OFS_OW_MODE:  rd_mux = {30'h0, ow_q};
      OFS_PAT_RSVD: rd_mux = 32'h0000_0000;
      OFS_SNR_THR:  rd_mux = {25'h0, snr_q};
      OFS_SWEEP:    rd_mux = {14'h0, sweep_q};
      OFS_STREAM:   rd_mux = {31'h0, stream_q};
      OFS_FRAMING:  rd_mux = {30'h0, frm_q};
      OFS_A6_MASK:  rd_mux = {24'h0, mask6_q};
      OFS_DEINT:    rd_mux = {31'h0, deint_q};
      OFS_CTL_SRC:  rd_mux = {30'h0, alm.ctl_src};
      OFS_REVISION: rd_mux = {24'h0, REVISION};
      OFS_ALM1:     rd_mux = {24'h0, alm.g1};
      OFS_ALM2:     rd_mux = {24'h0, sum_reg, alm.g2[6:0]};
      OFS_ALM3:     rd_mux = {24'h0, alm.g3 & MASK_A3};
      OFS_ALM4:     rd_mux = {24'h0, alm.g4};
      OFS_SHARED1:  rd_mux = {24'h0, alm.c1 & MASK_C1};
      OFS_SHARED2:  rd_mux = 32'h0000_0000;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Summary fault: failures, plus group 5 and 6 alarms only where allowed
  assign fault_any = |(alm.g1 & FAIL_A1) | |(alm.g2 & FAIL_A2)
                   | |(alm.g4 & FAIL_A4) | |(alm.c1 & MASK_C1)
                   | |(alm.g5 & mask5_q) | |(alm.g6 & mask6_q);

  // Decoded controls toward the datapath
  always_comb begin
    sum_next              = fault_any;
    ctl_next              = '0;
    ctl_next.inv_terr     = inv_q[0];
    ctl_next.inv_base     = inv_q[1];
    ctl_next.pair_swap    = pair_q;
    ctl_next.sp_enhanced  = spmode_q;
    ctl_next.sp_rs485     = spline_q;
    ctl_next.sp_baud      = BAUD_TAB[rate_q];
    ctl_next.sp_8bit      = char_q;
    ctl_next.oh_64k       = oh_q;
    ctl_next.ow_enable    = (ow_q != 2'h0);
    ctl_next.ow_only      = (ow_q == OW_ONLY);
    ctl_next.snr_thr      = snr_q;
    ctl_next.sweep_lim    = sweep_q;
    ctl_next.terr_burst   = stream_q;
    ctl_next.terr_unframed = (frm_q == FRM_NONE);
    unique case (frm_q)
      2'h0:    ctl_next.pkt_len = PKT_188;
      2'h1:    ctl_next.pkt_len = PKT_204;
      default: ctl_next.pkt_len = PKT_NONE;
    endcase
    ctl_next.deint_en     = deint_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum_reg <= 1'b0;
      ctl_reg <= '0;
    end else begin
      sum_reg <= sum_next;
      ctl_reg <= ctl_next;
    end
  end

  // Outputs straight from flops, except hresp, which is tied to OKAY
  assign hrdata        = rdata_reg;
  assign hreadyout     = rdy_reg;
  assign hresp         = 1'b0;
  assign ctl           = ctl_reg;
  assign summary_fault = sum_reg;

  // Checks next to the logic
  default clocking dcs_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_inv_both_set: assert property (inv_q == 2'h3 |=> ctl.inv_terr && ctl.inv_base)
    else $error("inversion code 3 not decoded to both paths");
  a_mask5_spare: assert property ((mask5_q & ~MASK_A5) == 8'h00)
    else $error("spare group 5 mask bit set");
  a_mask6_spare: assert property (mask6_q[7:3] == 5'h00)
    else $error("spare group 6 mask bit set");
  a_baud_map: assert property ($past(hresetn) |-> ctl.sp_baud == BAUD_TAB[$past(rate_q)])
    else $error("baud decode wrong");
  a_snr_range: assert property (snr_q <= 7'h63)
    else $error("threshold above 99");
  a_sweep_range: assert property (sweep_q <= 18'h3E418)
    else $error("sweep limit above 255000");
  a_frame_none: assert property (frm_q == FRM_NONE |=> ctl.pkt_len == PKT_NONE && ctl.terr_unframed)
    else $error("unframed code not decoded");
  a_fail_summary: assert property (alarm_pins.g1[1] [*3] |=> summary_fault)
    else $error("carrier loss did not raise summary");
  a_masked_quiet: assert property (!fault_any [*2] |-> !summary_fault)
    else $error("summary set with no allowed alarm");
  a_read_wait: assert property (addr_ph && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_rsvd_write: assert property (wr_reg && (addr_reg[7:6] != 2'h0 || addr_reg == OFS_PAT_RSVD)
    |=> $stable(ctl_next))
    else $error("ignored write changed a field");

  // Field decodes follow their registers one cycle later
  a_inv_terr: assert property (inv_q == 2'h1 |=> ctl.inv_terr && !ctl.inv_base)
    else $error("inversion code 1 decoded wrong");
  a_inv_base: assert property (inv_q == 2'h2 |=> !ctl.inv_terr && ctl.inv_base)
    else $error("inversion code 2 decoded wrong");
  a_pair_follow: assert property (ctl.pair_swap == $past(pair_q))
    else $error("pairing order not applied");
  a_port_mode: assert property (ctl.sp_enhanced == $past(spmode_q))
    else $error("port mode not applied");
  a_line_type: assert property (ctl.sp_rs485 == $past(spline_q))
    else $error("line type not applied");
  a_char_len: assert property (ctl.sp_8bit == $past(char_q))
    else $error("character length not applied");
  a_oh_type: assert property (ctl.oh_64k == $past(oh_q))
    else $error("overhead type not applied");
  a_ow_enable: assert property (ow_q == 2'h1 |=> ctl.ow_enable && !ctl.ow_only)
    else $error("orderwire enable decoded wrong");
  a_ow_range: assert property (ow_q != 2'h3)
    else $error("orderwire code 3 stored");
  a_snr_follow: assert property (ctl.snr_thr == $past(snr_q))
    else $error("threshold not applied");
  a_sweep_follow: assert property (ctl.sweep_lim == $past(sweep_q))
    else $error("sweep limit not applied");
  a_stream_mode: assert property (ctl.terr_burst == $past(stream_q))
    else $error("streaming mode not applied");
  a_frame_188: assert property (frm_q == 2'h0 |=> ctl.pkt_len == PKT_188 && !ctl.terr_unframed)
    else $error("188-byte framing decoded wrong");
  a_frame_204: assert property (frm_q == 2'h1 |=> ctl.pkt_len == PKT_204 && !ctl.terr_unframed)
    else $error("204-byte framing decoded wrong");
  a_deint_follow: assert property (ctl.deint_en == $past(deint_q))
    else $error("deinterleaver control not applied");
  a_write_nowait: assert property (addr_ph && hwrite |=> hreadyout)
    else $error("write inserted a wait state");

  // Status reads show the synchronised pins of the read cycle
  a_src_read: assert property (st_reg == ST_READ && hit_reg && addr_reg == OFS_CTL_SRC
    |=> hrdata == {30'h0, $past(alm.ctl_src)})
    else $error("control source read wrong");
  a_alm1_read: assert property (st_reg == ST_READ && hit_reg && addr_reg == OFS_ALM1
    |=> hrdata == {24'h0, $past(alm.g1)})
    else $error("group 1 read wrong");
  a_alm2_sum: assert property (st_reg == ST_READ && hit_reg && addr_reg == OFS_ALM2
    |=> hrdata[7] == $past(summary_fault))
    else $error("group 2 summary bit wrong");
  a_alm3_spare: assert property (st_reg == ST_READ && hit_reg && addr_reg == OFS_ALM3
    |=> hrdata[7] == 1'b0 && hrdata[1] == 1'b0)
    else $error("group 3 reserved bit set");
  a_test_lock: assert property (st_reg == ST_READ && hit_reg && addr_reg == OFS_ALM3
    |=> hrdata[5] == $past(alm.g3[5]))
    else $error("test pattern lock read wrong");
  a_alm4_read: assert property (st_reg == ST_READ && hit_reg && addr_reg == OFS_ALM4
    |=> hrdata == {24'h0, $past(alm.g4)})
    else $error("group 4 read wrong");

  c_read: cover property (addr_ph && !hwrite ##2 hreadyout);
  c_write: cover property (wsel[0] ##1 inv_q == 2'h3);
  c_summary: cover property ($rose(summary_fault));
  c_unframed: cover property (ctl.terr_unframed);
  c_status_read: cover property (st_reg == ST_READ && addr_reg == OFS_ALM2);
endmodule

// ==== dv/dcs_host_model.sv ====
// AHB-Lite host model that drives the configuration bank
`timescale 1ns/1ps
module dcs_host_model (
  input  wire logic        hclk,    // System clock
  input  wire logic        hready,  // Bus ready
  input  wire logic [31:0] hrdata,  // Read data
  output logic             hsel,    // Slave select
  output logic      [31:0] haddr,   // Byte address
  output logic      [1:0]  htrans,  // Transfer type
  output logic             hwrite,  // Write when high
  output logic      [2:0]  hsize,   // Always a word
  output logic      [31:0] hwdata,  // Write data
  output logic             hang     // A wait ran out
);
  // Bus idle from time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hang = 1'b0;
  end

  // Waits for the edge at which ready is sampled high, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1)
      hang <= 1'b1;
  endtask

  // One single word transfer; entered just after a rising edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rdv = hrdata;
  endtask
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the configuration and status bank
`timescale 1ns/1ps
module tb_top;
  import dcs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, hang, sfault;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  dcs_alarm_t  alm;
  dcs_ctl_t    ctl;
  int          error_cnt, n_compared;
  logic [6:0]  flags;
  logic [7:0]  bofs [7] = '{OFS_PAIR, OFS_SP_MODE, OFS_SP_LINE, OFS_SP_CHAR, OFS_OH_TYPE, OFS_STREAM, OFS_DEINT};
  logic [7:0]  pkt [3] = '{8'hBC, 8'hCC, 8'h00};
  localparam logic [7:0] REV = 8'h5A;  // Arbitrary revision value

  // One-bit decodes in the order of bofs
  assign flags = {ctl.deint_en, ctl.terr_burst, ctl.oh_64k, ctl.sp_8bit, ctl.sp_rs485, ctl.sp_enhanced,
                  ctl.pair_swap};

  dcs_top #(.REVISION(REV)) i_dcs_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .alarm_pins(alm), .ctl(ctl), .summary_fault(sfault)
  );
  dcs_host_model i_dcs_host_model (
    .hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hang(hang)
  );

  // 250 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Compares one value and counts it
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_dcs_host_model.xfer(a, 1'b1, d, v);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    i_dcs_host_model.xfer(a, 1'b0, 32'h0, v);
    chk(nm, v, e);
  endtask
  // Lets registered outputs land, then steps off the edge
  task automatic settle(input int c);
    repeat (c) @(posedge hclk);
    #1;
  endtask
  task automatic results;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A bus wait that ran out ends the run
  always @(posedge hang) begin
    error_cnt++;
    results();
  end

  initial begin
    error_cnt = 0;
    n_compared = 0;
    hresetn = 1'b0;
    alm = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    settle(2);
    // Decode of all-zero fields and reset contents
    chk("pkt_len", 32'(ctl.pkt_len), 32'hBC);
    chk("baud", 32'(ctl.sp_baud), 32'd150);
    chk("hresp", 32'(hresp), 32'h0);
    for (int a = 0; a < 64; a += 4)
      rc(8'(a), 32'h0, "reset");
    rc(OFS_REVISION, 32'(REV), "rev");
    // Inversion codes, then an out-of-range code
    for (int i = 0; i < 4; i++) begin
      wr(OFS_DATA_INV, 32'(i));
      settle(1);
      chk("inv", 32'({ctl.inv_base, ctl.inv_terr}), 32'(i));
    end
    wr(OFS_DATA_INV, 32'h4);
    rc(OFS_DATA_INV, 32'h3, "inv_rd");
    // Every rate code doubles the baud from 150
    for (int i = 0; i < 8; i++) begin
      wr(OFS_SP_RATE, 32'(i));
      settle(1);
      chk("baud", 32'(ctl.sp_baud), 32'(150 << i));
    end
    wr(OFS_SP_RATE, 32'h8);
    rc(OFS_SP_RATE, 32'h7, "rate_rd");
    // Orderwire and framing codes
    for (int i = 0; i < 3; i++) begin
      wr(OFS_OW_MODE, 32'(i));
      wr(OFS_FRAMING, 32'(i));
      settle(1);
      chk("ow_only", 32'(ctl.ow_only), 32'(i == 2));
      if (i < 2)
        chk("ow_en", 32'(ctl.ow_enable), 32'(i));
      chk("pkt", 32'(ctl.pkt_len), 32'(pkt[i]));
      chk("unframed", 32'(ctl.terr_unframed), 32'(i == 2));
    end
    wr(OFS_OW_MODE, 32'h3);
    wr(OFS_FRAMING, 32'h3);
    rc(OFS_OW_MODE, 32'h2, "ow_rd");
    rc(OFS_FRAMING, 32'h2, "frm_rd");
    // One-bit selectors: set, refuse 2, clear
    for (int k = 0; k < 7; k++) begin
      wr(bofs[k], 32'h1);
      wr(bofs[k], 32'h2);
      settle(1);
      chk("flag", 32'(flags), 32'(1 << k));
      rc(bofs[k], 32'h1, "flag_rd");
      wr(bofs[k], 32'h0);
    end
    settle(1);
    chk("flags", 32'(flags), 32'h0);
    // Threshold and sweep limit at the top of range and one past
    wr(OFS_SNR_THR, 32'd99);
    wr(OFS_SNR_THR, 32'd100);
    wr(OFS_SWEEP, 32'd255000);
    wr(OFS_SWEEP, 32'd255001);
    rc(OFS_SNR_THR, 32'd99, "snr");
    rc(OFS_SWEEP, 32'd255000, "sweep");
    chk("snr_ctl", 32'(ctl.snr_thr), 32'd99);
    chk("sweep_ctl", 32'(ctl.sweep_lim), 32'd255000);
    // Masks keep only their defined bits
    wr(OFS_A5_MASK, 32'hFF);
    wr(OFS_A6_MASK, 32'hFF);
    rc(OFS_A5_MASK, 32'h4D, "mask5");
    rc(OFS_A6_MASK, 32'h07, "mask6");
    // Masked alarms drop out of the summary
    alm.g5 <= 8'h01;
    alm.g6 <= 8'h04;
    settle(4);
    chk("sum", 32'(sfault), 32'h1);
    rc(OFS_ALM2, 32'h80, "alm2_sum");
    wr(OFS_A6_MASK, 32'h00);
    settle(3);
    chk("sum", 32'(sfault), 32'h1);
    wr(OFS_A5_MASK, 32'h00);
    settle(3);
    chk("sum", 32'(sfault), 32'h0);
    wr(OFS_A6_MASK, 32'h04);
    settle(3);
    chk("sum", 32'(sfault), 32'h1);
    // Status groups; activity and lock bits raise no fault
    alm <= '{ctl_src: 2'h0, g1: 8'h40, g2: 8'h00, g3: 8'hFF, g4: 8'h3F, g5: 8'h00, g6: 8'h00, c1: 8'h00};
    settle(4);
    chk("sum", 32'(sfault), 32'h0);
    rc(OFS_ALM1, 32'h40, "alm1");
    rc(OFS_ALM3, 32'h7D, "alm3");
    rc(OFS_ALM4, 32'h3F, "alm4");
    for (int i = 0; i < 3; i++) begin
      alm.ctl_src <= 2'(i);
      settle(3);
      rc(OFS_CTL_SRC, 32'(i), "ctl_src");
    end
    alm.g1 <= 8'h42;
    alm.g2 <= 8'h7F;
    alm.g4 <= 8'hC0;
    alm.c1 <= 8'hFF;
    settle(4);
    chk("sum", 32'(sfault), 32'h1);
    rc(OFS_ALM2, 32'hFF, "alm2");
    rc(OFS_ALM4, 32'hC0, "alm4");
    rc(OFS_SHARED1, 32'h07, "shared1");
    rc(OFS_SHARED2, 32'h00, "shared2");
    // Read-only, reserved and unmapped places ignore writes
    wr(OFS_ALM1, 32'hFF);
    wr(OFS_REVISION, 32'h00);
    wr(OFS_PAT_RSVD, 32'h05);
    wr(8'h80, 32'h01);
    rc(OFS_ALM1, 32'h42, "alm1_ro");
    rc(OFS_DATA_INV, 32'h3, "alias");
    rc(OFS_REVISION, 32'(REV), "rev_ro");
    rc(OFS_PAT_RSVD, 32'h00, "rsvd");
    rc(8'h60, 32'h00, "unmapped");
    results();
  end
endmodule
